/* File: rtl/vic_defines.vh */
// constants of the vectored interrupt controller
// What this block does
// (R1) user vector number is request number plus eight.
// (R2) vector eight's primary entry sits at 0x000014, two units per vector.
// (R3) alternate entries sit 0x100 above the primary entries.
// (R4) vectors zero to seven are traps; primary from 0x000004, alternate from 0x000104.
// (R5) capture 1,2,3 to requests 1,5,37; compare 1,2 to 2,6.
// (R6) external pins 0,1,2 to requests 0,20,29; pin change to 19.
// (R7) converter 13, two-wire target 16, controller 17, comparator 18.
// (R8) pulse period 57, first fault 63, second fault 64.
// (R9) calendar 62, serial port error 65, charge-time unit 77.
// (R10) serial periph error 9, done 10; serial rx 11, tx 12.
// (R11) timers one to three at 3,7,8; four and five at 27,28 on large parts.
// (R12) second pulse fault request never raised on smallest parts.
// (R13) twenty-six registers: two global, flags, enables, priorities, pending vector.
// (R14) first global register holds nesting disable and trap control/status flags.
// (R15) second global register holds external request config and alternate table select.
// (R16) request flag set by source, stays set until software clears it.
// (R17) each source has an enable; disabled sources raise no interrupt.
// (R18) at equal priority the lowest vector number wins.
// (R19) alternate select takes all interrupt and trap vectors from alternate table.
// (R20) each user source gets one of eight priority levels; the arbiter treats level zero as disabled, so only levels 1 to 7 raise.
// (R21) pending vector register latches vector number and priority level.
// (R22) flagged and enabled sources combine into one CPU request with vector.
// (R23) reserved request numbers never raise and their flags read zero.
`ifndef VIC_DEFINES_VH
`define VIC_DEFINES_VH
`define VIC_NUM_IRQ 80
`define VIC_VEC_OFFSET 7'h08
`define VIC_IVT_BASE 24'h00_0004
`define VIC_ALTERNATE_VECTOR_TABLE_DELTA 24'h00_0100
// register indices on the plain port
`define VIC_A_CTL1 5'h00
`define VIC_A_CTL2 5'h01
`define VIC_A_FLAG0 5'h02
`define VIC_A_EN0 5'h07
`define VIC_A_PRI0 5'h0C
`define VIC_A_PEND 5'h19
`define VIC_NUM_PRI_REGS 13
// implemented request numbers, one bit each
`define VIC_IMPL_MASK 80'h2003_C200_0020_381F_3FEF
`define VIC_IRQ_TIMER4 27
`define VIC_IRQ_TIMER5 28
`define VIC_IRQ_FAULT2 64
`define VIC_CTL1_NEST_BIT 15
`define VIC_CTL2_ALT_BIT 15
`define VIC_CTL2_EDGE_W 3
`define VIC_TRAP_W 8
`endif

/* File: rtl/vic_trap_unit.v */
// trap capture and trap vector selection
`timescale 1ns/100ps
`include "vic_defines.vh"
module vic_trap_unit (
  input wire ref_clk_i,
  input wire rst_b_i,
  input wire [7:0] trap_i,
  input wire [7:0] clr_i,
  output reg [7:0] status_o,
  output wire trap_req_o,
  output reg [2:0] trap_vec_o
);
  integer i;
  // ****************************************
  // sticky trap flags
  // ****************************************
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      status_o <= 8'h00;
    end else begin
      // set wins over clear; vectors 0,5,6,7 reserved
      status_o <= ((status_o & ~clr_i) | trap_i) & 8'h1E; // (R4) (R14)
    end
  end
  assign trap_req_o = |status_o;
  always @* begin
    trap_vec_o = 3'h0;
    for (i = 7; i >= 0; i = i - 1) begin
      if (status_o[i]) begin
        trap_vec_o = i[2:0];
      end
    end
  end
endmodule

/* File: rtl/vic_arbiter.v */
// priority arbiter over all user requests
`timescale 1ns/100ps
`include "vic_defines.vh"
module vic_arbiter (
  input wire [79:0] active_i,
  input wire [239:0] prio_i,
  output reg found_o,
  output reg [6:0] irq_o,
  output reg [2:0] level_o
);
  integer i;
  reg [2:0] p;
  // ****************************************
  // highest level, then lowest number
  // ****************************************
  always @* begin
    found_o = 1'b0;
    irq_o = 7'h00;
    level_o = 3'h0;
    p = 3'h0;
    // level zero means disabled, as in the core convention
    for (i = 79; i >= 0; i = i - 1) begin
      p = prio_i[i*3 +: 3];
      if (active_i[i] && p != 3'h0 && (!found_o || p >= level_o)) begin // (R18) (R20)
        found_o = 1'b1;
        irq_o = i[6:0];
        level_o = p;
      end
    end
  end
endmodule

/* File: rtl/vic_top.v */
// vectored interrupt controller top
`timescale 1ns/100ps
`include "vic_defines.vh"
module vic_top (
  input wire ref_clk_i,
  input wire rst_b_i,
  input wire [4:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [15:0] rdata_o,
  input wire large_mem_i,
  input wire small_pkg_i,
  input wire ext_pin_request_zero,
  input wire ext_pin_request_one,
  input wire ext_pin_request_two,
  input wire pin_change_request_i,
  input wire capture_one_request,
  input wire capture_two_request,
  input wire capture_three_request,
  input wire compare_one_request,
  input wire compare_two_request,
  input wire timer_one_request,
  input wire timer_two_request,
  input wire timer_three_request,
  input wire timer_four_request,
  input wire timer_five_request,
  input wire serial_periph_error_request,
  input wire serial_periph_done_request_i,
  input wire serial_port_rx_request,
  input wire serial_port_tx_request,
  input wire serial_port_error_request,
  input wire converter_done_request,
  input wire twowire_target_request,
  input wire twowire_controller_request,
  input wire comparator_request,
  input wire pulse_period_request,
  input wire pulse_fault_first_request,
  input wire pulse_fault_second_request,
  input wire calendar_clock_request,
  input wire charge_time_request,
  input wire [7:0] trap_i,
  input wire int_ack_i,
  output reg cpu_req_o,
  output reg [6:0] vector_num_o,
  output reg [23:0] vector_addr_o,
  output reg [3:0] level_o
);
  // ****************************************
  // pin synchronisers and edge detection
  // ****************************************
  reg [2:0] pin_s1;
  reg [2:0] pin_s2;
  reg [2:0] pin_s3;
  reg [15:0] ctl1;
  reg [15:0] ctl2;
  reg [79:0] flags;
  reg [79:0] enables;
  reg [239:0] prio;
  reg [79:0] raw;
  reg [79:0] sw_set;
  reg [79:0] sw_clr;
  reg [7:0] trap_clr;
  wire [7:0] trap_status;
  wire trap_req;
  wire [2:0] trap_vec;
  wire found;
  wire [6:0] win_irq;
  wire [2:0] win_lvl;
  wire [79:0] impl_mask;
  wire [2:0] pin_edge;
  reg [6:0] pend_vec;
  reg [3:0] pend_lvl;
  integer k;
  integer j;

  // ****************************************
  // priority register decode
  // ****************************************
  // only the groups of four that hold a real source get a register,
  // so thirteen registers reach every implemented request
  function [4:0] pri_group;
    input [4:0] idx;
    begin
      case (idx)
        5'h00: pri_group = 5'h00;
        5'h01: pri_group = 5'h01;
        5'h02: pri_group = 5'h02;
        5'h03: pri_group = 5'h03;
        5'h04: pri_group = 5'h04;
        5'h05: pri_group = 5'h05;
        5'h06: pri_group = 5'h06;
        5'h07: pri_group = 5'h07;
        5'h08: pri_group = 5'h09;
        5'h09: pri_group = 5'h0E;
        5'h0A: pri_group = 5'h0F;
        5'h0B: pri_group = 5'h10;
        5'h0C: pri_group = 5'h13;
        default: pri_group = 5'h1F;
      endcase
    end
  endfunction

  // four levels of one group, one per nibble, top bit of each nibble zero
  function [15:0] prio_word;
    input [239:0] v;
    input [4:0] grp;
    begin
      prio_word = {1'b0, v[grp*12+9 +: 3], 1'b0, v[grp*12+6 +: 3], 1'b0, v[grp*12+3 +: 3], 1'b0, v[grp*12 +: 3]};
    end
  endfunction

  // entry address of a vector in either table
  function [23:0] vec_addr;
    input [6:0] vec;
    input alt;
    begin
      vec_addr = `VIC_IVT_BASE + {16'h0000, vec, 1'b0} + (alt ? `VIC_ALTERNATE_VECTOR_TABLE_DELTA : 24'h00_0000); // (R2) (R3) (R4) (R19)
    end
  endfunction

  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
      pin_s3 <= 3'h0;
    end else begin
      pin_s1 <= {ext_pin_request_two, ext_pin_request_one, ext_pin_request_zero};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end
  // ctl2 low bits pick falling edge per pin, as external config
  assign pin_edge = (pin_s2 ^ pin_s3) & (pin_s2 ^ ctl2[`VIC_CTL2_EDGE_W-1:0]); // (R15)

  // ****************************************
  // source to request mapping
  // ****************************************
  always @* begin
    raw = 80'h0;
    raw[0] = pin_edge[0]; // (R6)
    raw[20] = pin_edge[1]; // (R6)
    raw[29] = pin_edge[2]; // (R6)
    raw[19] = pin_change_request_i; // (R6)
    raw[1] = capture_one_request; // (R5)
    raw[2] = compare_one_request; // (R5)
    raw[5] = capture_two_request; // (R5)
    raw[6] = compare_two_request; // (R5)
    raw[37] = capture_three_request; // (R5)
    raw[3] = timer_one_request; // (R11)
    raw[7] = timer_two_request; // (R11)
    raw[8] = timer_three_request; // (R11)
    raw[`VIC_IRQ_TIMER4] = timer_four_request; // (R11)
    raw[`VIC_IRQ_TIMER5] = timer_five_request; // (R11)
    raw[9] = serial_periph_error_request; // (R10)
    raw[10] = serial_periph_done_request_i; // (R10)
    raw[11] = serial_port_rx_request; // (R10)
    raw[12] = serial_port_tx_request; // (R10)
    raw[13] = converter_done_request; // (R7)
    raw[16] = twowire_target_request; // (R7)
    raw[17] = twowire_controller_request; // (R7)
    raw[18] = comparator_request; // (R7)
    raw[57] = pulse_period_request; // (R8)
    raw[63] = pulse_fault_first_request; // (R8)
    raw[`VIC_IRQ_FAULT2] = pulse_fault_second_request; // (R8)
    raw[62] = calendar_clock_request; // (R9)
    raw[65] = serial_port_error_request; // (R9)
    raw[77] = charge_time_request; // (R9)
  end

  // variant straps read each cycle; tying them is the integrator's job
  assign impl_mask = `VIC_IMPL_MASK
    & ~({79'h0, ~large_mem_i} << `VIC_IRQ_TIMER4) & ~({79'h0, ~large_mem_i} << `VIC_IRQ_TIMER5) // (R11)
    & ~({79'h0, small_pkg_i} << `VIC_IRQ_FAULT2); // (R12) (R23)

  // ****************************************
  // software write decode
  // ****************************************
  always @* begin
    sw_set = 80'h0;
    sw_clr = 80'h0;
    trap_clr = 8'h00;
    if (wr_i && addr_i >= `VIC_A_FLAG0 && addr_i < `VIC_A_EN0) begin
      for (k = 0; k < 80; k = k + 1) begin
        if (k / 16 == addr_i - `VIC_A_FLAG0) begin
          sw_set[k] = wdata_i[k % 16];
          sw_clr[k] = ~wdata_i[k % 16];
        end
      end
    end
    if (wr_i && addr_i == `VIC_A_CTL1) begin
      trap_clr = ~wdata_i[`VIC_TRAP_W-1:0]; // (R14)
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctl1 <= 16'h0000;
      ctl2 <= 16'h0000;
      flags <= 80'h0;
      enables <= 80'h0;
      prio <= 240'h0;
    end else begin
      // hardware set beats a software clear in the same cycle
      flags <= ((flags & ~sw_clr) | sw_set | raw) & impl_mask; // (R16) (R23)
      if (wr_i) begin
        case (addr_i)
          `VIC_A_CTL1: ctl1 <= {wdata_i[`VIC_CTL1_NEST_BIT], 15'h0000}; // (R14)
          `VIC_A_CTL2: ctl2 <= wdata_i; // (R15)
          default: begin
            for (j = 0; j < 80; j = j + 1) begin
              if (addr_i >= `VIC_A_EN0 && addr_i < `VIC_A_PRI0 && j / 16 == addr_i - `VIC_A_EN0) begin
                enables[j] <= wdata_i[j % 16] & impl_mask[j]; // (R17)
              end
              if (addr_i >= `VIC_A_PRI0 && addr_i < `VIC_A_PEND && j / 4 == pri_group(addr_i - `VIC_A_PRI0)) begin
                prio[j*3 +: 3] <= wdata_i[(j % 4)*4 +: 3]; // (R20)
              end
            end
          end
        endcase
      end
    end
  end

  vic_trap_unit u_trap (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .trap_i(trap_i),
    .clr_i(trap_clr),
    .status_o(trap_status),
    .trap_req_o(trap_req),
    .trap_vec_o(trap_vec)
  );

  vic_arbiter u_arb (
    .active_i(flags & enables), // (R17) (R22)
    .prio_i(prio),
    .found_o(found),
    .irq_o(win_irq),
    .level_o(win_lvl)
  );

  // ****************************************
  // pending vector and cpu request
  // ****************************************
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cpu_req_o <= 1'b0;
      vector_num_o <= 7'h00;
      vector_addr_o <= `VIC_IVT_BASE;
      level_o <= 4'h0;
      pend_vec <= 7'h00;
      pend_lvl <= 4'h0;
    end else begin
      cpu_req_o <= trap_req | found; // (R22)
      if (trap_req) begin
        // traps outrank every user level
        vector_num_o <= {4'h0, trap_vec}; // (R4)
        vector_addr_o <= vec_addr({4'h0, trap_vec}, ctl2[`VIC_CTL2_ALT_BIT]); // (R19)
        level_o <= 4'h8;
      end else if (found) begin
        vector_num_o <= win_irq + `VIC_VEC_OFFSET; // (R1)
        vector_addr_o <= vec_addr(win_irq + `VIC_VEC_OFFSET, ctl2[`VIC_CTL2_ALT_BIT]); // (R2) (R19)
        level_o <= {1'b0, win_lvl};
      end
      if (int_ack_i) begin
        pend_vec <= vector_num_o; // (R21)
        pend_lvl <= level_o; // (R21)
      end
    end
  end

  // ****************************************
  // read port, 26 registers
  // ****************************************
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      if (addr_i == `VIC_A_CTL1) begin
        rdata_o <= ctl1 | {8'h00, trap_status}; // (R13) (R14)
      end else if (addr_i == `VIC_A_CTL2) begin
        rdata_o <= ctl2;
      end else if (addr_i < `VIC_A_EN0) begin
        rdata_o <= flags[(addr_i - `VIC_A_FLAG0)*16 +: 16];
      end else if (addr_i < `VIC_A_PRI0) begin
        rdata_o <= enables[(addr_i - `VIC_A_EN0)*16 +: 16];
      end else if (addr_i < `VIC_A_PEND) begin
        rdata_o <= prio_word(prio, pri_group(addr_i - `VIC_A_PRI0)); // (R20)
      end else if (addr_i == `VIC_A_PEND) begin
        rdata_o <= {4'h0, pend_lvl, 1'b0, pend_vec}; // (R21)
      end else begin
        rdata_o <= 16'h0000;
      end
    end else begin
      rdata_o <= 16'h0000;
    end
  end
endmodule

/* File: dv/vic_top_sva.sv */
// concurrent checks on the interrupt controller top ports
`timescale 1ns/100ps
`include "vic_defines.vh"
module vic_top_sva (
  input logic ref_clk_i,
  input logic rst_b_i,
  input logic [4:0] addr_i,
  input logic rd_i,
  input logic [15:0] rdata_o,
  input logic large_mem_i,
  input logic small_pkg_i,
  input logic [7:0] trap_i,
  input logic cpu_req_o,
  input logic [6:0] vector_num_o,
  input logic [23:0] vector_addr_o,
  input logic [3:0] level_o
);
  localparam logic [79:0] IMPL = `VIC_IMPL_MASK;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_trap_in;
    |trap_i[4:1];
  endsequence
  sequence s_trap_out;
    ##[1:2] (cpu_req_o && level_o == 4'd8);
  endsequence
  a_trap_served: assert property (s_trap_in |-> s_trap_out) else $error("trap not served");
  a_addr_map: assert property (cpu_req_o |->
    (vector_addr_o - 24'h00_0004 - {vector_num_o, 1'b0}) inside {24'h00_0000, 24'h00_0100})
    else $error("vector address off");
  a_trap_level: assert property (cpu_req_o && vector_num_o < 7'd8 |->
    level_o == 4'd8 && vector_num_o inside {[1:4]}) else $error("bad trap level");
  a_user_level: assert property (cpu_req_o && vector_num_o >= 7'd8 |->
    level_o inside {[1:7]}) else $error("bad user level");
  a_reserved_vec: assert property (cpu_req_o && vector_num_o >= 7'd8 |->
    IMPL[vector_num_o - 7'd8]) else $error("reserved vector");
  a_read_idle: assert property (!$past(rd_i) |-> rdata_o == 16'h0000) else $error("stray read data");
  a_unmapped_zero: assert property (rd_i && addr_i > 5'd25 |=> rdata_o == 16'h0000) else $error("unmapped read");
  a_small_pkg: assert property (small_pkg_i && $past(small_pkg_i, 3) |->
    !(cpu_req_o && vector_num_o == 7'd72)) else $error("fault two raised");
  a_large_mem: assert property (!large_mem_i && !$past(large_mem_i, 3) |->
    !(cpu_req_o && vector_num_o inside {7'd35, 7'd36})) else $error("timer four five raised");
endmodule
bind vic_top vic_top_sva u_sva (.ref_clk_i, .rst_b_i, .addr_i, .rd_i, .rdata_o, .large_mem_i,
  .small_pkg_i, .trap_i, .cpu_req_o, .vector_num_o, .vector_addr_o, .level_o);

/* File: dv/vic_cpu_model.sv */
// cpu core model: acknowledges a standing request after a delay
`timescale 1ns/100ps
module vic_cpu_model #(parameter int DLY = 3) (
  input logic ref_clk_i,
  input logic rst_b_i,
  input logic req_i,
  input logic en_i,
  output logic ack_o
);
  logic [3:0] cnt;
  // one acknowledge per request, never a held level
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt <= '0;
      ack_o <= 1'b0;
    end else begin
      ack_o <= req_i && en_i && cnt == DLY;
      if (!(req_i && en_i)) cnt <= '0;
      else if (cnt != 4'hF) cnt <= cnt + 4'h1;
    end
  end
endmodule

/* File: dv/vic_top_tb.sv */
// self-checking bench for the interrupt controller top
`timescale 1ns/100ps
module vic_top_tb;
  logic clk = 0, rst_b = 0, wr = 0, rd = 0, lm = 1, sp = 0, ack_en = 0, ack;
  logic [4:0] addr = '0;
  logic [15:0] wdata = '0, rdata;
  logic [27:0] s = '0;
  logic [7:0] trap = '0;
  logic req, ack_d;
  logic [6:0] vn;
  logic [23:0] va;
  logic [3:0] lv;
  int mismatches = 0, checked = 0;
  int irq[28] = '{0, 20, 29, 19, 1, 5, 37, 2, 6, 3, 7, 8, 27, 28, 9, 10, 11, 12, 65, 13, 16, 17, 18, 57,
    63, 64, 62, 77};
  initial forever #5 clk = ~clk;
  vic_top DUT (.ref_clk_i(clk), .rst_b_i(rst_b), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .large_mem_i(lm), .small_pkg_i(sp), .ext_pin_request_zero(s[0]),
    .ext_pin_request_one(s[1]), .ext_pin_request_two(s[2]), .pin_change_request_i(s[3]),
    .capture_one_request(s[4]), .capture_two_request(s[5]), .capture_three_request(s[6]),
    .compare_one_request(s[7]), .compare_two_request(s[8]), .timer_one_request(s[9]),
    .timer_two_request(s[10]), .timer_three_request(s[11]), .timer_four_request(s[12]),
    .timer_five_request(s[13]), .serial_periph_error_request(s[14]), .serial_periph_done_request_i(s[15]),
    .serial_port_rx_request(s[16]), .serial_port_tx_request(s[17]), .serial_port_error_request(s[18]),
    .converter_done_request(s[19]), .twowire_target_request(s[20]), .twowire_controller_request(s[21]),
    .comparator_request(s[22]), .pulse_period_request(s[23]), .pulse_fault_first_request(s[24]),
    .pulse_fault_second_request(s[25]), .calendar_clock_request(s[26]), .charge_time_request(s[27]),
    .trap_i(trap), .int_ack_i(ack), .cpu_req_o(req), .vector_num_o(vn), .vector_addr_o(va), .level_o(lv));
  vic_cpu_model CPU (.ref_clk_i(clk), .rst_b_i(rst_b), .req_i(req), .en_i(ack_en), .ack_o(ack));
  // ****************************************
  // access and compare tasks
  // ****************************************
  task chk(input string n, input logic [23:0] e, input logic [23:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task wrr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask
  task rdr(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a; rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 chk("rdata", {8'h00, e}, {8'h00, rdata});
  endtask
  // pins are synchronised and edge detected, so hold long enough
  task pulse(input int i);
    @(posedge clk);
    s[i] <= 1;
    repeat (4) @(posedge clk);
    s[i] <= 0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task tend(input string n);
    $display("test %s done", n);
  endtask
  task results;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    results;
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1;
    #1 chk("addr", 24'h00_0004, va);
    rdr(0, 0); rdr(1, 0); rdr(25, 0); rdr(31, 0);
    wrr(31, 16'hFFFF); rdr(31, 0);
    tend("reset");
    for (int k = 7; k < 12; k++) wrr(k[4:0], 16'hFFFF);
    for (int k = 12; k < 25; k++) wrr(k[4:0], 16'h1111);
    rdr(7, 16'h3FEF); rdr(10, 16'hC200);
    rdr(11, 16'h2003);
    for (int i = 0; i < 28; i++) begin
      pulse(i);
      chk("req", 1, req);
      chk("vec", irq[i] + 8, vn);
      chk("addr", 24'h00_0014 + 2 * irq[i], va);
      chk("lvl", 1, lv);
      rdr(2 + irq[i] / 16, 16'h0001 << (irq[i] % 16));
      wrr(2 + irq[i] / 16, 0);
    end
    tend("map");
    @(posedge clk);
    s[9] <= 1; s[19] <= 1;
    @(posedge clk);
    s[9] <= 0; s[19] <= 0;
    repeat (3) @(posedge clk);
    #1 chk("vec", 11, vn);
    wrr(15, 16'h1151);
    repeat (2) @(posedge clk);
    #1 chk("vec", 21, vn);
    chk("lvl", 5, lv);
    ack_en <= 1;
    repeat (8) @(posedge clk);
    ack_en <= 0;
    rdr(25, 16'h0515);
    wrr(2, 0); wrr(15, 16'h1111);
    tend("priority");
    wrr(1, 16'h8000);
    pulse(9);
    chk("addr", 24'h00_011A, va);
    wrr(2, 0);
    @(posedge clk);
    trap <= 8'h04;
    @(posedge clk);
    trap <= 0;
    repeat (3) @(posedge clk);
    #1 chk("vec", 2, vn);
    chk("lvl", 8, lv);
    chk("addr", 24'h00_0108, va);
    rdr(0, 16'h0004);
    wrr(0, 16'h8000); rdr(0, 16'h8000);
    wrr(0, 0); rdr(1, 16'h8000);
    wrr(1, 16'h8001); pulse(0);
    chk("req", 0, req);
    rdr(2, 16'h0001);
    wrr(2, 0); wrr(1, 0);
    tend("alternate and trap");
    wrr(7, 16'h3FE7);
    pulse(9);
    chk("req", 0, req);
    rdr(2, 16'h0008);
    wrr(2, 0); wrr(7, 16'hFFFF);
    lm <= 0; sp <= 1;
    pulse(12); pulse(25);
    chk("req", 0, req);
    rdr(3, 0); rdr(6, 0);
    tend("masking and variants");
    results;
  end
endmodule
